// ==== core/psc_status_ctrl.sv ====
// current status control register and event recognition logic
// Overview of operation
// - timer off bit 17 suppresses the timer interrupt
// - otherwise timer follows reload enable; disable-all overrides both
// - pending bit 14 set while requests are active but blocked
// - each instruction completed in run mode copies trace enable into trace pending
// - trace pending at one raises a trace trap
// - align check bit 11 traps unaligned word or half-word data addresses
// - no alignment check when bit clear, for I/O, or for fetches
// - hold bit 10 freezes saved-state registers except explicit moves
// - hold bit is set whenever an interrupt or trap is taken
// - lock bit 9 forces bus lock, else atomic instructions drive it
// - idle bit 7 stops work; left on taken event or reset
// - data translated only with bit 6 clear and instruction phys bit clear
// - fetches translated only when bit 5 is clear
// - supervisor bit 4 allows all context; user access traps
// - events occur on conditions; taken only when enables and mode allow
// - mask field 3-2 enables requests 0..mask; request 0 never masked by the field
// - external off bit ignores external requests only
// - disable-all keeps only warning and access-exception traps
`timescale 1ns/10ps
`default_nettype none
`include "psc_defines.svh"
module psc_status_ctrl
  import psc_pkg::*;
#(
  parameter int N_IRQ = `PSC_NUM_IRQ
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // register move port
  input  wire logic             i_wr,
  input  wire logic [31:0]      i_wdata,
  output logic [31:0]           o_rdata,
  // event sources
  input  wire logic [N_IRQ-1:0] i_ext_req,
  input  wire logic             i_timer_req,
  input  wire logic             i_timer_reload_ie,
  input  wire psc_trap_t        i_trap,
  input  wire logic             i_instr_done,
  input  wire logic             i_halt,
  // memory access and context checks
  input  wire psc_acc_t         i_acc,
  input  wire logic             i_prot_access,
  input  wire logic             i_atomic_lock,
  // results
  output logic                  o_take,
  output logic                  o_trace_trap,
  output logic                  o_align_trap,
  output logic                  o_prot_trap,
  output logic                  o_timer_irq,
  output logic                  o_ext_irq,
  output logic                  o_hold_state,
  output logic                  o_bus_lock,
  output logic                  o_idle,
  output logic                  o_xlate_data,
  output logic                  o_xlate_fetch,
  output logic                  o_privileged
);
  logic [31:0]      csr;
  logic             irq_waiting;
  logic [N_IRQ-1:0] ext_en;
  logic             ext_blocked;
  logic             all_off;
  logic             trap_any;
  logic             trap_exempt;
  logic             occurred;
  logic             next_take;
  psc_mode_t        mode;

  assign all_off = csr[`PSC_BIT_ALL_OFF];

  psc_irq_mask #(.N(N_IRQ)) u_mask (
    .i_mask    (csr[`PSC_BIT_MASK_HI:`PSC_BIT_MASK_LO]),
    .i_ext_off (csr[`PSC_BIT_EXT_OFF]),
    .i_all_off (all_off),
    .i_req     (i_ext_req),
    .o_enabled (ext_en),
    .o_blocked (ext_blocked)
  );

  // timer recognition
  assign o_timer_irq = i_timer_req && !csr[`PSC_BIT_TMR_OFF]
                       && i_timer_reload_ie && !all_off;
  assign o_ext_irq = |ext_en;

  // trace trap from pending bit
  assign o_trace_trap = csr[`PSC_BIT_TR_PEND] && !all_off;

  // alignment check, data accesses only
  always_comb begin
    o_align_trap = 1'b0;
    if (csr[`PSC_BIT_ALIGN] && i_acc.valid && !i_acc.is_io && !i_acc.is_fetch) begin
      if (i_acc.is_word && (|i_acc.addr_lo)) begin
        o_align_trap = 1'b1;
      end else if (i_acc.is_half && i_acc.addr_lo[0]) begin
        o_align_trap = 1'b1;
      end
    end
  end

  // user mode touching protected context
  assign o_prot_trap = i_prot_access && !csr[`PSC_BIT_PRIV];

  // exempt traps pass disable-all; others need it clear
  assign trap_exempt = i_trap.warn || i_trap.iae || i_trap.dae;
  assign trap_any = trap_exempt || ((i_trap.other_trap || o_align_trap || o_prot_trap)
                    && !all_off);
  // occurred is merely the condition; halt blocks recognition
  assign occurred  = trap_any || o_trace_trap || o_timer_irq || o_ext_irq;
  assign next_take = occurred && !i_halt;
  assign o_take    = next_take;

  // translation and mode outputs
  assign o_xlate_data  = !csr[`PSC_BIT_PHYS_D] && !i_acc.phys_bit;
  assign o_xlate_fetch = !csr[`PSC_BIT_PHYS_I];
  assign o_privileged  = csr[`PSC_BIT_PRIV];
  assign o_hold_state  = csr[`PSC_BIT_HOLD];
  // lock either forced or driven by atomic instructions
  assign o_bus_lock = csr[`PSC_BIT_LOCK] || i_atomic_lock;
  assign o_idle     = (mode == PSC_IDLE);

  // status word; hardware events win over a move in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      csr <= `PSC_RESET_VALUE;
    end else begin
      if (i_wr) begin
        csr <= i_wdata & `PSC_WR_MASK;
      end
      if (i_instr_done && mode == PSC_RUN) begin
        csr[`PSC_BIT_TR_PEND] <= i_wr ? i_wdata[`PSC_BIT_TR_EN]
                                       : csr[`PSC_BIT_TR_EN];
      end
      if (next_take) begin
        csr[`PSC_BIT_HOLD] <= 1'b1;
        csr[`PSC_BIT_IDLE] <= 1'b0;
      end
    end
  end

  // pending flag recomputed every cycle from the requests
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_waiting <= 1'b0;
    end else begin
      irq_waiting <= ext_blocked;
    end
  end

  // run / idle mode tracking follows the idle bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode <= PSC_RUN;
    end else if (next_take) begin
      mode <= PSC_RUN;
    end else if (csr[`PSC_BIT_IDLE]) begin
      mode <= PSC_IDLE;
    end else begin
      mode <= PSC_RUN;
    end
  end

  // readback: reserved bits are zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= (csr & `PSC_WR_MASK) | ({31'h0000_0000, irq_waiting} << `PSC_BIT_IRQ_WAIT);
    end
  end

  // assertions
  timer_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    csr[`PSC_BIT_TMR_OFF] |-> !o_timer_irq) else $error("timer irq while disabled");
  timer_ie_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_timer_req && i_timer_reload_ie && !csr[`PSC_BIT_TMR_OFF] && !all_off) |-> o_timer_irq)
    else $error("timer irq lost");
  pend_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ((|i_ext_req) && !o_ext_irq) |=> irq_waiting) else $error("pending not set");
  trace_copy_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_instr_done && mode == PSC_RUN && !i_wr) |=> csr[`PSC_BIT_TR_PEND] == $past(csr[`PSC_BIT_TR_EN]))
    else $error("trace copy wrong");
  trace_trap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (csr[`PSC_BIT_TR_PEND] && !all_off) |-> o_trace_trap) else $error("trace trap missing");
  align_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (csr[`PSC_BIT_ALIGN] && i_acc.valid && !i_acc.is_io && !i_acc.is_fetch && i_acc.is_word
     && i_acc.addr_lo != 2'h0) |-> o_align_trap) else $error("unaligned word missed");
  align_skip_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!csr[`PSC_BIT_ALIGN] || i_acc.is_io || i_acc.is_fetch) |-> !o_align_trap)
    else $error("alignment trap when exempt");
  hold_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
    next_take |=> o_hold_state) else $error("hold not set on take");
  idle_exit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    next_take |=> ##1 !o_idle) else $error("idle not left");
  lock_force_a: assert property (@(posedge i_clk) disable iff (i_rst)
    csr[`PSC_BIT_LOCK] |-> o_bus_lock) else $error("lock not forced");
  user_prot_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_prot_access && !o_privileged) |-> o_prot_trap) else $error("protection missed");
  halt_block_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_halt |-> !o_take) else $error("taken in halt");
  all_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (all_off && !trap_exempt) |-> !o_take) else $error("event taken under disable-all");
  ext_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (csr[`PSC_BIT_EXT_OFF]) |-> !o_ext_irq) else $error("external irq while off");

  take_c:  cover property (@(posedge i_clk) disable iff (i_rst) o_take);
  idle_c:  cover property (@(posedge i_clk) disable iff (i_rst) o_idle ##1 !o_idle);
  pend_c:  cover property (@(posedge i_clk) disable iff (i_rst) irq_waiting);
  align_c: cover property (@(posedge i_clk) disable iff (i_rst) o_align_trap);
endmodule
`default_nettype wire

// ==== core/psc_defines.svh ====
// bit positions, reset value and request count of the status control block
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
`define PSC_BIT_TMR_OFF   17
`define PSC_BIT_IRQ_WAIT  14
`define PSC_BIT_TR_EN     13
`define PSC_BIT_TR_PEND   12
`define PSC_BIT_ALIGN     11
`define PSC_BIT_HOLD      10
`define PSC_BIT_LOCK      9
`define PSC_BIT_IDLE      7
`define PSC_BIT_PHYS_D    6
`define PSC_BIT_PHYS_I    5
`define PSC_BIT_PRIV      4
`define PSC_BIT_MASK_HI   3
`define PSC_BIT_MASK_LO   2
`define PSC_BIT_EXT_OFF   1
`define PSC_BIT_ALL_OFF   0
// writable bits; reserved positions and the pending bit are not stored
`define PSC_WR_MASK       32'h0002_3EFF
// supervisor mode, disable-all and external off set after reset
`define PSC_RESET_VALUE   32'h0000_0013
`define PSC_NUM_IRQ       4
`endif

// ==== core/psc_pkg.sv ====
// types shared by the status control block
package psc_pkg;
  // access request from the load/store and fetch units
  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        is_fetch;
    logic        is_word;
    logic        is_half;
    logic        phys_bit;
    logic [1:0]  addr_lo;
  } psc_acc_t;
  // event sources presented to the recognition logic
  typedef struct packed {
    logic warn;
    logic iae;
    logic dae;
    logic other_trap;
  } psc_trap_t;
  typedef enum logic [1:0] {
    PSC_RUN  = 2'b00,
    PSC_IDLE = 2'b01
  } psc_mode_t;
endpackage

// ==== core/psc_irq_mask.sv ====
// external request masking by priority field and disables
`timescale 1ns/10ps
`default_nettype none
module psc_irq_mask
  import psc_pkg::*;
#(
  parameter int N = 4
) (
  // controls
  input  wire logic [1:0]   i_mask,
  input  wire logic         i_ext_off,
  input  wire logic         i_all_off,
  // requests
  input  wire logic [N-1:0] i_req,
  // results
  output logic [N-1:0]      o_enabled,
  output logic              o_blocked
);
  // request k passes when k <= mask field; request 0 always passes the field
  genvar k;
  generate
    for (k = 0; k < N; k++) begin : g_en
      assign o_enabled[k] = i_req[k] && (k <= int'(i_mask)) && !i_ext_off && !i_all_off;
    end
  endgenerate
  // some request active, none allowed through
  assign o_blocked = (|i_req) && !(|o_enabled);
endmodule
`default_nettype wire

// ==== sim/psc_irq_src.sv ====
// external request sources standing on the far side of the block
`timescale 1ns/10ps
`default_nettype none
module psc_irq_src (
  // clock
  input  wire logic       i_clk,
  // bench command and request lines
  input  wire logic [3:0] i_cmd,
  output logic [3:0]      o_ext_req
);
  // levels stand until the bench withdraws them, never pulsed,
  // since a request dropped before acknowledge gives unpredictable results
  always_ff @(posedge i_clk) begin
    o_ext_req <= i_cmd;
  end
endmodule
`default_nettype wire

// ==== sim/psc_status_ctrl_tb_top.sv ====
// self-checking testbench of the status control block
`timescale 1ns/10ps
`default_nettype none
module psc_status_ctrl_tb_top;
  import psc_pkg::*;
  logic        i_clk = 0, i_rst = 1, i_wr = 0, i_timer_req = 0, i_timer_reload_ie = 0;
  logic        i_instr_done = 0, i_halt = 0, i_prot_access = 0, i_atomic_lock = 0;
  logic [31:0] i_wdata = '0;
  logic [31:0] o_rdata;
  logic [3:0]  req_cmd = '0;
  logic [3:0]  i_ext_req;
  psc_trap_t   i_trap = '0;
  psc_acc_t    i_acc = '0;
  logic        o_take, o_trace_trap, o_align_trap, o_prot_trap, o_timer_irq, o_ext_irq;
  logic        o_hold_state, o_bus_lock, o_idle, o_xlate_data, o_xlate_fetch, o_privileged;
  logic [31:0] v;
  logic [8:0]  tab [6] = '{9'h191, 9'h192, 9'h189, 9'h08A, 9'h0D1, 9'h0B1};
  int          error_cnt = 0;
  int          checked = 0;
  // 200 MHz clock
  always #2.5 i_clk = ~i_clk;
  psc_irq_src u_psc_irq_src (.i_clk, .i_cmd(req_cmd), .o_ext_req(i_ext_req));
  psc_status_ctrl u_psc_status_ctrl (.i_clk, .i_rst, .i_wr, .i_wdata, .o_rdata, .i_ext_req,
    .i_timer_req, .i_timer_reload_ie, .i_trap, .i_instr_done, .i_halt, .i_acc,
    .i_prot_access, .i_atomic_lock, .o_take, .o_trace_trap, .o_align_trap, .o_prot_trap,
    .o_timer_irq, .o_ext_irq, .o_hold_state, .o_bus_lock, .o_idle, .o_xlate_data,
    .o_xlate_fetch, .o_privileged);
  // one comparison, counted
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // wait n edges and let the last one's updates land
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // move into the status word; controls settle after the taking edge
  task automatic wr(input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    #1;
  endtask
  task automatic t_reg();
    tick(1);
    chk("reset word", o_rdata, 32'h0000_0013);
    wr(32'hFFFF_FFFF);
    chk("lock forced", o_bus_lock, 1);
    tick(1);
    chk("reserved bits", o_rdata, 32'h0002_3EFF);
    $display("test reg done");
  endtask
  // mask codes 0..3, then external off, then disable-all
  task automatic t_mask();
    for (int m = 0; m < 6; m++) begin
      for (int k = 0; k < 4; k++) begin
        wr(m < 4 ? 32'h10 | (m << 2) : (m == 4 ? 32'h1E : 32'h1D));
        @(posedge i_clk);
        req_cmd <= 4'h1 << k;
        tick(2);
        chk("ext enable", o_ext_irq, m < 4 && k <= m);
        tick(1);
        chk("pending set", o_rdata[14], !(m < 4 && k <= m));
        @(posedge i_clk);
        req_cmd <= 4'h0;
        tick(4);
        chk("pending clear", o_rdata[14], 0);
      end
    end
    $display("test mask done");
  endtask
  task automatic t_timer();
    for (int c = 0; c < 8; c++) begin
      wr(32'h10 | (32'(c & 1) << 17) | 32'(c >> 1 & 1));
      @(posedge i_clk);
      i_timer_reload_ie <= c[2];
      i_timer_req       <= 1'b1;
      tick(1);
      chk("timer irq", o_timer_irq, c == 4);
    end
    // timer left pending and enabled, so halt has something to block
    wr(32'h10);
    chk("timer taken", o_take, 1);
    i_halt <= 1'b1;
    tick(1);
    chk("halt blocks", o_take, 0);
    i_halt      <= 1'b0;
    i_timer_req <= 1'b0;
    $display("test timer done");
  endtask
  task automatic t_trace();
    wr(32'h2010);
    chk("hold clear", o_hold_state, 0);
    @(posedge i_clk);
    i_instr_done <= 1'b1;
    @(posedge i_clk);
    i_instr_done <= 1'b0;
    #1;
    chk("trace trap", o_trace_trap, 1);
    tick(2);
    chk("pending copy", o_rdata[12], 1);
    chk("hold on take", o_rdata[10], 1);
    chk("hold out", o_hold_state, 1);
    $display("test trace done");
  endtask
  task automatic t_access();
    wr(32'h0810);
    for (int i = 0; i < 6; i++) begin
      i_acc <= tab[i][7:0];
      tick(1);
      chk("align trap", o_align_trap, tab[i][8]);
    end
    // unaligned data word stays on the bus while the check is switched off
    i_acc <= 8'h91;
    wr(32'h10);
    chk("align off", o_align_trap, 0);
    chk("xlate data", o_xlate_data, 1);
    chk("xlate fetch", o_xlate_fetch, 1);
    i_acc         <= 8'h94;
    i_prot_access <= 1'b1;
    tick(1);
    chk("instr phys", o_xlate_data, 0);
    chk("super ok", o_prot_trap, 0);
    wr(32'h60);
    chk("data phys", o_xlate_data, 0);
    chk("fetch phys", o_xlate_fetch, 0);
    chk("user trap", o_prot_trap, 1);
    chk("user mode", o_privileged, 0);
    i_prot_access <= 1'b0;
    wr(32'h10);
    i_atomic_lock <= 1'b1;
    tick(1);
    chk("atomic lock", o_bus_lock, 1);
    i_atomic_lock <= 1'b0;
    tick(1);
    chk("lock free", o_bus_lock, 0);
    $display("test access done");
  endtask
  task automatic t_idle();
    wr(32'h91);
    @(posedge i_clk);
    req_cmd <= 4'h1;
    tick(4);
    chk("idle kept", o_idle, 1);
    wr(32'h90);
    tick(4);
    chk("idle left", o_idle, 0);
    chk("idle bit", o_rdata[7], 0);
    req_cmd <= 4'h0;
    $display("test idle done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #60000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reg();
    t_mask();
    t_timer();
    t_trace();
    t_access();
    t_idle();
    give_verdict();
  end
endmodule
`default_nettype wire
